// ==== shared/dlsq_regs.vh ====
// constants for the DLL relock / frequency change / write leveling sequencer
// assumes a 25 MHz system clock; memory pins are sampled, never used as clocks
//
// Behaviour
// [R1] controller starts DLL-on switch from idle, RTT off
// [R2] controller waits tCKSRE, then stable clock tCKSRX
// [R3] CKE high from SR exit through tDLLK
// [R4] ODT low through tDLLK if ODT was enabled
// [R5] after tXS, MR1 A0=0 enables DLL
// [R6] after tMRD, MR0 A8=1 resets DLL
// [R7] reprogram CL, CWL, WR; ZQCL after tMOD
// [R8] wait tMOD; locked-DLL commands after tDLLK
// [R9] clock change only in SR or PPD
// [R10] device ignores clock in SR after tCKSRE
// [R11] PPD change: tCKSRE after CKE low, ODT low
// [R12] ODT and CKE held low during change
// [R13] stable clock before PPD exit, then DLL reset
// [R14] relock period: ODT low, CKE high
// [R15] MR1 A7 enters and leaves write leveling
// [R16] MR1 A12 disables output buffer
// [R17] leveling: ODT switches DQS termination only
// [R18] RTT_Nom limited when outputs enabled
// [R19] DQ undefined on entry; only NOP allowed
// [R20] ODT accepted tMOD after leveling entry
// [R21] controller launches single strobe edge after tWLMRD
// [R22] sample CK on strobe rise, return on DQ
// [R23] feedback per byte lane, upper and lower
// [R24] feedback valid within tWLO
// [R25] prime-DQ mode holds other DQs low
// [R26] controller counts each wait in cycles
`ifndef DLSQ_REGS_VH
`define DLSQ_REGS_VH

// register byte offsets
`define DLSQ_CTRL_OFS 4'h0
`define DLSQ_STAT_OFS 4'h4
`define DLSQ_MR0_OFS 4'h8
`define DLSQ_MR1_OFS 4'hC

// control fields and reset value
`define DLSQ_CTRL_PRIME_BIT 0
`define DLSQ_CTRL_ERRCLR_BIT 1
`define DLSQ_CTRL_RST 32'h00000000

// mode register fields
`define DLSQ_MR1_DLL_DIS_BIT 0
`define DLSQ_MR1_WLVL_BIT 7
`define DLSQ_MR1_QOFF_BIT 12
`define DLSQ_MR1_RTT_LO_BIT 2
`define DLSQ_MR1_RTT_MID_BIT 6
`define DLSQ_MR1_RTT_HI_BIT 9
`define DLSQ_MR0_DLL_RST_BIT 8
`define DLSQ_MR_RST 16'h0000

// states
`define DLSQ_ST_IDLE 2'h0
`define DLSQ_ST_SREF 2'h1
`define DLSQ_ST_PPD 2'h2

// timing
`define DLSQ_CLK_PERIOD_PS 40000
`define DLSQ_TCKSRE_PS 10000
`define DLSQ_TCKSRE_CYC ((`DLSQ_TCKSRE_PS + `DLSQ_CLK_PERIOD_PS - 1) / `DLSQ_CLK_PERIOD_PS)
`define DLSQ_TDLLK_NCK 512
`define DLSQ_TMOD_NCK 12

`endif

// ==== rtl/dlsq_sync.v ====
// two-stage synchroniser for a group of pin levels
// assumes the inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dlsq_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/dlsq_top.v ====
// device-side sequencer: self-refresh / power-down tracking, DLL relock,
// write leveling feedback and termination control, AXI4-Lite status port
// assumes memory pins arrive asynchronously and are oversampled by CLOCK
`timescale 1ns/1ps
`default_nettype none
`include "dlsq_regs.vh"
module dlsq_top #(
    parameter TDLLK_NCK = `DLSQ_TDLLK_NCK,
    parameter TMOD_NCK = `DLSQ_TMOD_NCK
) (
    // clock and reset
    input wire CLOCK,
    input wire NRST,
    // memory command pins
    input wire CK,
    input wire CKE,
    input wire ODT,
    input wire CS_N,
    input wire RAS_N,
    input wire CAS_N,
    input wire WE_N,
    input wire [2:0] BA,
    input wire [15:0] ADDR,
    // strobes, true side per byte lane
    input wire DQS_L,
    input wire DQS_U,
    // data pins and termination
    output reg [15:0] DQ_O,
    output reg [15:0] DQ_OE_N,
    output reg RTT_DQS_ON,
    output reg RTT_DQ_ON,
    // axi4-lite slave
    input wire [3:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [3:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    reg rst_meta_r;
    reg rst_n_r;
    wire rst_n;

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_n_r;

    wire [27:0] pins_s;

    // lower strobe in bit 0 so the strobe index matches the DQ byte lane
    dlsq_sync #(.W(28)) dlsq_sync_i (
        .clk(CLOCK),
        .rst_n(rst_n),
        .din({CK, CKE, ODT, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR, DQS_U, DQS_L}),
        .dout(pins_s)
    );

    wire ck_s = pins_s[27];
    wire cke_s = pins_s[26];
    wire odt_s = pins_s[25];
    wire [3:0] cmd_s = pins_s[24:21];
    wire [2:0] ba_s = pins_s[20:18];
    wire [15:0] addr_s = pins_s[17:2];
    wire [1:0] dqs_s = pins_s[1:0];

    reg ck_d_r;
    reg [1:0] dqs_d_r;
    wire ck_rise = ck_s & ~ck_d_r;
    wire [1:0] dqs_rise = dqs_s & ~dqs_d_r;

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            ck_d_r <= 1'b0;
            dqs_d_r <= 2'h0;
        end else begin
            ck_d_r <= ck_s;
            dqs_d_r <= dqs_s;
        end
    end

    // ------------------------------------------------------------
    // command decode and power state
    // ------------------------------------------------------------
    localparam [3:0] CMD_MRS = 4'h0;
    localparam [3:0] CMD_REF = 4'h1;

    reg [1:0] state_r;
    reg cke_prev_r;
    reg [15:0] mr0_r;
    reg [15:0] mr1_r;
    reg odt_feat_r;
    reg [3:0] sre_cnt_r;
    reg clk_ignored_r;
    reg relock_r;
    reg [9:0] dllk_cnt_r;
    reg dll_locked_r;
    reg [4:0] wl_odt_cnt_r;
    reg seq_err_r;
    reg [31:0] ctrl_r;
    reg aw_got_r;
    reg w_got_r;
    reg [3:0] aw_addr_r;
    reg [31:0] w_data_r;

    wire is_mrs = ck_rise & cke_s & (cmd_s == CMD_MRS);
    wire wlvl = mr1_r[`DLSQ_MR1_WLVL_BIT];
    wire qoff = mr1_r[`DLSQ_MR1_QOFF_BIT];
    wire dll_on = ~mr1_r[`DLSQ_MR1_DLL_DIS_BIT];
    wire rtt_nom_en = mr1_r[`DLSQ_MR1_RTT_HI_BIT] | mr1_r[`DLSQ_MR1_RTT_MID_BIT] |
                      mr1_r[`DLSQ_MR1_RTT_LO_BIT];
    wire wl_odt_ok = (wl_odt_cnt_r == 5'h00);
    wire wr_fire = aw_got_r & w_got_r & ~S_AXI_BVALID;
    wire err_clr = wr_fire & (aw_addr_r == `DLSQ_CTRL_OFS) & w_data_r[`DLSQ_CTRL_ERRCLR_BIT];
    wire relock_bad = relock_r & (~cke_s | (odt_feat_r & odt_s));

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `DLSQ_ST_IDLE;
            cke_prev_r <= 1'b0;
            mr0_r <= `DLSQ_MR_RST;
            mr1_r <= `DLSQ_MR_RST;
            odt_feat_r <= 1'b0;
            sre_cnt_r <= 4'h0;
            clk_ignored_r <= 1'b0;
        end else begin
            if (ck_rise) begin
                cke_prev_r <= cke_s;
            end
            case (state_r)
                `DLSQ_ST_IDLE: begin
                    if (ck_rise & cke_prev_r & ~cke_s) begin
                        odt_feat_r <= rtt_nom_en;
                        sre_cnt_r <= 4'h0;
                        clk_ignored_r <= 1'b0;
                        state_r <= (cmd_s == CMD_REF) ? `DLSQ_ST_SREF : `DLSQ_ST_PPD;
                    end
                    if (is_mrs & (ba_s == 3'h0)) begin
                        mr0_r <= addr_s; // R7
                    end
                    if (is_mrs & (ba_s == 3'h1)) begin
                        mr1_r <= addr_s; // R5 R15 R16
                    end
                end
                `DLSQ_ST_SREF, `DLSQ_ST_PPD: begin
                    // clock is a don't care once tCKSRE has passed
                    if (sre_cnt_r < `DLSQ_TCKSRE_CYC) begin
                        sre_cnt_r <= sre_cnt_r + 4'h1;
                    end else begin
                        clk_ignored_r <= 1'b1; // R10
                    end
                    // exit is taken from the CKE level, not a clock edge
                    if (cke_s & clk_ignored_r) begin
                        state_r <= `DLSQ_ST_IDLE;
                        cke_prev_r <= 1'b1;
                    end
                end
                default: begin
                    state_r <= `DLSQ_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // DLL relock window and leveling ODT acceptance
    // ------------------------------------------------------------
    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            relock_r <= 1'b0;
            dllk_cnt_r <= 10'h000;
            dll_locked_r <= 1'b0;
            wl_odt_cnt_r <= 5'h00;
            seq_err_r <= 1'b0;
        end else begin
            if ((state_r != `DLSQ_ST_IDLE) & cke_s & clk_ignored_r) begin
                relock_r <= 1'b1;
                dll_locked_r <= 1'b0;
                dllk_cnt_r <= 10'h000;
            end else if (is_mrs & (ba_s == 3'h0) & addr_s[`DLSQ_MR0_DLL_RST_BIT] & dll_on) begin
                dllk_cnt_r <= TDLLK_NCK[9:0]; // R6 R13
                dll_locked_r <= 1'b0;
            end else if (ck_rise & (dllk_cnt_r != 10'h000)) begin
                dllk_cnt_r <= dllk_cnt_r - 10'h001;
                if (dllk_cnt_r == 10'h001) begin
                    dll_locked_r <= 1'b1; // R8
                    relock_r <= 1'b0;
                end
            end
            if (is_mrs & (ba_s == 3'h1) & addr_s[`DLSQ_MR1_DLL_DIS_BIT]) begin
                dll_locked_r <= 1'b0;
            end
            // odt is only honoured tMOD after the leveling entry write
            if (is_mrs & (ba_s == 3'h1) & addr_s[`DLSQ_MR1_WLVL_BIT] & ~wlvl) begin
                wl_odt_cnt_r <= TMOD_NCK[4:0]; // R20
            end else if (ck_rise & ~wl_odt_ok) begin
                wl_odt_cnt_r <= wl_odt_cnt_r - 5'h01;
            end
            // set wins over a simultaneous software clear
            if (relock_bad) begin
                seq_err_r <= 1'b1; // R3 R4 R14
            end else if (err_clr) begin
                seq_err_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // termination and leveling feedback
    // ------------------------------------------------------------
    reg [1:0] ck_smp_r;
    wire prime_only = ctrl_r[`DLSQ_CTRL_PRIME_BIT];
    wire odt_live = odt_s & (state_r == `DLSQ_ST_IDLE);

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            ck_smp_r <= 2'h0;
            DQ_O <= 16'h0000;
            DQ_OE_N <= 16'hFFFF;
            RTT_DQS_ON <= 1'b0;
            RTT_DQ_ON <= 1'b0;
        end else begin
            // each lane's strobe samples the clock level
            if (dqs_rise[0]) begin
                ck_smp_r[0] <= ck_s; // R22 R23
            end
            if (dqs_rise[1]) begin
                ck_smp_r[1] <= ck_s; // R22 R23
            end
            if (wlvl) begin
                RTT_DQS_ON <= odt_live & wl_odt_ok; // R17
                RTT_DQ_ON <= 1'b0; // R17
            end else begin
                RTT_DQS_ON <= odt_live & rtt_nom_en;
                RTT_DQ_ON <= odt_live & rtt_nom_en;
            end
            if (wlvl & ~qoff) begin
                DQ_OE_N <= 16'h0000; // R16 R19
                if (prime_only) begin
                    DQ_O <= {7'h00, ck_smp_r[1], 7'h00, ck_smp_r[0]}; // R25
                end else begin
                    DQ_O <= {{8{ck_smp_r[1]}}, {8{ck_smp_r[0]}}}; // R24
                end
            end else begin
                DQ_OE_N <= 16'hFFFF; // R16
                DQ_O <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    reg [3:0] w_strb_r;
    reg [31:0] rd_nxt;
    reg rd_ok_nxt;
    wire [31:0] status = {22'h0, seq_err_r, wl_odt_ok, qoff, wlvl, dll_locked_r,
                          dll_on, relock_r, clk_ignored_r, state_r};
    integer i;

    assign S_AXI_AWREADY = ~aw_got_r & ~S_AXI_BVALID;
    assign S_AXI_WREADY = ~w_got_r & ~S_AXI_BVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;

    always @* begin
        rd_nxt = 32'h00000000;
        rd_ok_nxt = 1'b1;
        case (S_AXI_ARADDR)
            `DLSQ_CTRL_OFS: rd_nxt = ctrl_r;
            `DLSQ_STAT_OFS: rd_nxt = status;
            `DLSQ_MR0_OFS: rd_nxt = {16'h0000, mr0_r};
            `DLSQ_MR1_OFS: rd_nxt = {16'h0000, mr1_r};
            default: rd_ok_nxt = 1'b0;
        endcase
    end

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            ctrl_r <= `DLSQ_CTRL_RST;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RRESP <= 2'h0;
            S_AXI_RDATA <= 32'h00000000;
        end else begin
            if (S_AXI_AWVALID & S_AXI_AWREADY) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                w_got_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                // only control is writable; the clear bit is self-clearing
                if (aw_addr_r == `DLSQ_CTRL_OFS) begin
                    S_AXI_BRESP <= 2'h0;
                    for (i = 0; i < 4; i = i + 1) begin
                        if (w_strb_r[i]) begin
                            ctrl_r[i*8 +: 8] <= w_data_r[i*8 +: 8];
                        end
                    end
                    ctrl_r[`DLSQ_CTRL_ERRCLR_BIT] <= 1'b0;
                end else begin
                    S_AXI_BRESP <= 2'h2;
                end
            end else if (S_AXI_BVALID & S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            if (S_AXI_ARVALID & S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_nxt;
                S_AXI_RRESP <= rd_ok_nxt ? 2'h0 : 2'h2;
            end else if (S_AXI_RVALID & S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/dlsq_props.sv ====
// checker on the sequencer top ports: leveling feedback, termination, axi handshakes
// assumes memory pins are asynchronous to CLOCK and oversampled by it
`timescale 1ns/1ps
`default_nettype none
module dlsq_props #(
    parameter TDLLK_NCK = 8,
    parameter TMOD_NCK = 3
) (
    // clock, reset and memory pins
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CK,
    input wire logic ODT,
    input wire logic DQS_L,
    input wire logic DQS_U,
    input wire logic [15:0] DQ_O,
    input wire logic [15:0] DQ_OE_N,
    input wire logic RTT_DQS_ON,
    input wire logic RTT_DQ_ON,
    // axi4-lite
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // ------------------------------
    // clock level caught at each strobe rise
    // ------------------------------
    logic dl_d, du_d, ckl_r, cku_r;
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            {dl_d, du_d, ckl_r, cku_r} <= 4'h0;
        end else begin
            dl_d <= DQS_L;
            du_d <= DQS_U;
            if (DQS_L && !dl_d)
                ckl_r <= CK;
            if (DQS_U && !du_d)
                cku_r <= CK;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    property p_dq_term; DQ_OE_N != 16'hFFFF |-> !RTT_DQ_ON; endproperty
    a_dq_term: assert property (p_dq_term) else $error("dq termination on during feedback");
    property p_term_off; !ODT [*6] |=> !RTT_DQS_ON && !RTT_DQ_ON; endproperty
    a_term_off: assert property (p_term_off) else $error("termination on with odt low");
    property p_lane; !DQ_OE_N[0] |-> DQ_O[7:0] inside {8'h00, 8'h01, 8'hFF}; endproperty
    a_lane: assert property (p_lane) else $error("lower lane feedback not uniform");
    property p_fb_lo; $rose(DQS_L) && !DQ_OE_N[0] |-> ##[3:8] DQ_O[0] == ckl_r; endproperty
    a_fb_lo: assert property (p_fb_lo) else $error("lower feedback wrong or late");
    property p_fb_hi; $rose(DQS_U) && !DQ_OE_N[8] |-> ##[3:8] DQ_O[8] == cku_r; endproperty
    a_fb_hi: assert property (p_fb_hi) else $error("upper feedback wrong or late");
    property p_wr_ans;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write response missing");
    property p_rd_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read data missing");
    property p_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_busy: assert property (p_busy) else $error("write accepted while response pending");
    property p_rdone; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
    a_rdone: assert property (p_rdone) else $error("read data not retired");
    c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_term: cover property (RTT_DQS_ON && !DQ_OE_N[0]);
    c_fb: cover property ($rose(DQ_O[0]) && !DQ_OE_N[0]);
endmodule
bind dlsq_top dlsq_props #(.TDLLK_NCK(TDLLK_NCK), .TMOD_NCK(TMOD_NCK)) dlsq_props_i (
    .CLOCK(CLOCK), .NRST(NRST), .CK(CK), .ODT(ODT), .DQS_L(DQS_L), .DQS_U(DQS_U),
    .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .RTT_DQS_ON(RTT_DQS_ON), .RTT_DQ_ON(RTT_DQ_ON),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
);
`default_nettype wire

// ==== verif/dlsq_mc.sv ====
// memory controller model: memory clock, command pins, cke, odt, strobes
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
`default_nettype none
module dlsq_mc (
    // clock and control
    output var logic CK,
    output var logic CKE,
    output var logic ODT,
    output var logic CS_N,
    output var logic RAS_N,
    output var logic CAS_N,
    output var logic WE_N,
    // address and strobes
    output var logic [2:0] BA,
    output var logic [15:0] ADDR,
    output var logic DQS_L,
    output var logic DQS_U
);
    // ------------------------------
    // free clock, halted by the bench only in self refresh
    // ------------------------------
    logic ck_run;
    initial begin
        {CK, CKE, ODT, DQS_L, DQS_U} = 5'h08;
        {CS_N, RAS_N, CAS_N, WE_N} = 4'hF;
        BA = 3'h0;
        ADDR = 16'h0000;
        ck_run = 1'b1;
        #13;
        forever begin
            #160;
            if (ck_run)
                CK = ~CK;
        end
    end
    // changed at a falling edge so the rising edge sees it settled
    task automatic cmd(input logic [3:0] p, input logic [2:0] b, input logic [15:0] a,
                       input logic cke, input logic odt);
        @(negedge CK);
        {CS_N, RAS_N, CAS_N, WE_N} = p;
        BA = b;
        ADDR = a;
        CKE = cke;
        ODT = odt;
        @(negedge CK);
        {CS_N, RAS_N, CAS_N, WE_N} = 4'h7;
        BA = ~b; // stale address would hide a late sample
        ADDR = ~a;
    endtask
    task automatic strobe(input logic up, input int dly);
        @(posedge CK);
        #(dly);
        if (up)
            DQS_U = 1'b1;
        else
            DQS_L = 1'b1;
        #120;
        DQS_L = 1'b0;
        DQS_U = 1'b0;
        @(negedge CK);
    endtask
endmodule
`default_nettype wire

// ==== verif/dlsq_bench.sv ====
// bench: controller model on the memory pins, axi4-lite master on the registers
// assumes tDLLK and tMOD scaled to 8 and 3 memory clocks
`timescale 1ns/1ps
`default_nettype none
`include "dlsq_regs.vh"
module dlsq_bench;
    logic CLOCK, NRST, CK, CKE, ODT, CS_N, RAS_N, CAS_N, WE_N, DQS_L, DQS_U;
    logic RTT_DQS_ON, RTT_DQ_ON, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic [2:0] BA;
    logic [15:0] ADDR, DQ_O, DQ_OE_N;
    logic [3:0] S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
    logic sl[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    int sd[5] = '{200, 60, 60, 200, 60};
    logic [15:0] se[5] = '{16'h0000, 16'h00FF, 16'hFFFF, 16'hFF00, 16'h0101};
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    dlsq_top #(.TDLLK_NCK(8), .TMOD_NCK(3)) dlsq_top_i (.*);
    dlsq_mc dlsq_mc_i (.*);

    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    // ------------------------------
    // tasks
    // ------------------------------
    task automatic final_report;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wck(input int n);
        repeat (n) @(posedge CK);
    endtask
    task automatic mrs(input logic [2:0] b, input logic [15:0] a, input logic o, input int n);
        dlsq_mc_i.cmd(4'h0, b, a, 1'b1, o);
        wck(n);
    endtask
    task automatic pins(input logic [3:0] p, input logic cke);
        dlsq_mc_i.cmd(p, 3'h0, 16'h0000, cke, 1'b0);
        wck(2);
    endtask
    // decisions taken mid-cycle, so they match what the next rising edge samples
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge CLOCK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        while (!(aw_ok && w_ok)) begin
            @(negedge CLOCK);
            aw_ok = aw_ok || (S_AXI_AWVALID && S_AXI_AWREADY);
            w_ok = w_ok || (S_AXI_WVALID && S_AXI_WREADY);
            @(posedge CLOCK);
            S_AXI_AWVALID <= !aw_ok;
            S_AXI_WVALID <= !w_ok;
        end
        do @(negedge CLOCK); while (!S_AXI_BVALID);
        rsp = S_AXI_BRESP;
        @(posedge CLOCK);
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge CLOCK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        do @(negedge CLOCK); while (!S_AXI_ARREADY);
        @(posedge CLOCK);
        S_AXI_ARVALID <= 1'b0;
        do @(negedge CLOCK); while (!S_AXI_RVALID);
        rd = S_AXI_RDATA;
        rsp = S_AXI_RRESP;
        @(posedge CLOCK);
        S_AXI_RREADY <= 1'b0;
        check(rd & m, e);
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        NRST = 1'b0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB} = 12'h00F;
        S_AXI_WDATA = 32'h00000000;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        repeat (12) @(posedge CLOCK);
        NRST <= 1'b1;
        repeat (3) @(posedge CLOCK);
        rd_chk(`DLSQ_CTRL_OFS, 32'hFFFFFFFF, `DLSQ_CTRL_RST);
        check({30'h0, rsp}, 32'h00000000);
        // no leveling odt wait pending after reset, so bit 8 reads set
        rd_chk(`DLSQ_STAT_OFS, 32'h000003DF, 32'h00000110);
        axi_wr(`DLSQ_STAT_OFS, 32'h00000001);
        check({30'h0, rsp}, 32'h00000002);
        // unaligned address decodes to nothing
        rd_chk(4'h2, 32'hFFFFFFFF, 32'h00000000);
        check({30'h0, rsp}, 32'h00000002);
        // odt already high at entry must wait out tMOD; rtt_nom RZQ/4 with outputs on
        mrs(3'h1, 16'h0084, 1'b1, 1);
        check({31'h0, RTT_DQS_ON}, 32'h0);
        wck(4);
        check({30'h0, RTT_DQS_ON, RTT_DQ_ON}, 32'h2);
        check({16'h0, DQ_OE_N}, 32'h0);
        rd_chk(`DLSQ_STAT_OFS, 32'h000000C0, 32'h00000040);
        rd_chk(`DLSQ_MR1_OFS, 32'h0000FFFF, 32'h00000084);
        pins(4'h7, 1'b1);
        check({30'h0, RTT_DQS_ON, RTT_DQ_ON}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            if (i == 4)
                axi_wr(`DLSQ_CTRL_OFS, 32'h00000001);
            dlsq_mc_i.strobe(sl[i], sd[i]);
            check({16'h0, DQ_O}, {16'h0, se[i]});
        end
        mrs(3'h1, 16'h1080, 1'b0, 1);
        check({16'h0, DQ_OE_N}, 32'h0000FFFF);
        mrs(3'h1, 16'h0000, 1'b0, 3);
        rd_chk(`DLSQ_STAT_OFS, 32'h000000C0, 32'h0);
        axi_wr(`DLSQ_CTRL_OFS, 32'h00000000);
        check({30'h0, rsp}, 32'h00000000);
        // self refresh with the clock stopped, then dll relock
        pins(4'h1, 1'b0);
        rd_chk(`DLSQ_STAT_OFS, 32'h00000007, 32'h00000005);
        dlsq_mc_i.ck_run = 1'b0;
        #3000;
        dlsq_mc_i.ck_run = 1'b1;
        wck(4);
        pins(4'h7, 1'b1);
        rd_chk(`DLSQ_STAT_OFS, 32'h0000020B, 32'h00000008);
        mrs(3'h1, 16'h0000, 1'b0, 3);
        mrs(3'h0, 16'h0100, 1'b0, 12);
        rd_chk(`DLSQ_STAT_OFS, 32'h00000238, 32'h00000030);
        rd_chk(`DLSQ_MR0_OFS, 32'h0000FFFF, 32'h00000100);
        // power-down, then cke dropped inside the relock period
        pins(4'h7, 1'b0);
        rd_chk(`DLSQ_STAT_OFS, 32'h00000003, 32'h00000002);
        pins(4'h7, 1'b1);
        pins(4'h7, 1'b0);
        pins(4'h7, 1'b1);
        rd_chk(`DLSQ_STAT_OFS, 32'h00000208, 32'h00000208);
        mrs(3'h0, 16'h0100, 1'b0, 12);
        axi_wr(`DLSQ_CTRL_OFS, 32'h00000002);
        rd_chk(`DLSQ_STAT_OFS, 32'h0000020B, 32'h00000000);
        final_report();
    end
endmodule
`default_nettype wire
